// ===== design/deiu_top.v
// error status, enables and interrupt pin of the dual channel bridge
`timescale 1ns/10ps
`include "deiu_consts.vh"
module deiu_top (
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  // channel a detect strobes
  input wire first_chan_sync_fault_i,
  input wire first_chan_checksum_fault_i,
  input wire first_chan_header_uncorrectable_i,
  input wire first_chan_header_corrected_i,
  input wire first_chan_protocol_fault_i,
  input wire first_chan_lane_merge_fault_i,
  input wire first_chan_leader_fault_i,
  // channel b detect strobes
  input wire second_chan_sync_fault_i,
  input wire second_chan_checksum_fault_i,
  input wire second_chan_header_uncorrectable_i,
  input wire second_chan_header_corrected_i,
  input wire second_chan_protocol_fault_i,
  input wire second_chan_lane_merge_fault_i,
  input wire second_chan_leader_fault_i,
  // pll lock level from analog
  input wire pll_lock_i,
  // interrupt pin
  output wire irq_o,
  output wire irq_oe_o
);
  // ************************************************
  // pll lock synchroniser and edge detect
  // ************************************************
  wire lock_s;
  reg lock_d_ff;
  deiu_sync2 u_lock_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .d_i(pll_lock_i),
    .q_o(lock_s)
  );
  // previous lock level for the falling edge
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
      lock_d_ff <= 1'b0;
    else
      lock_d_ff <= lock_s;
  end
  wire lock_lost = lock_d_ff & ~lock_s;

  // ************************************************
  // event vectors, strobes never gated by soft reset
  // ************************************************
  reg [7:0] set_a;
  reg [7:0] set_b;
  always @*
  begin
    set_a = `DEIU_RST_ZERO;
    set_b = `DEIU_RST_ZERO;
    set_a[`DEIU_BIT_SYNC] = first_chan_sync_fault_i;
    set_a[`DEIU_BIT_CRC] = first_chan_checksum_fault_i;
    set_a[`DEIU_BIT_UNC] = first_chan_header_uncorrectable_i;
    set_a[`DEIU_BIT_COR] = first_chan_header_corrected_i;
    set_a[`DEIU_BIT_LLP] = first_chan_protocol_fault_i
      | first_chan_lane_merge_fault_i;
    set_a[`DEIU_BIT_SOT] = first_chan_leader_fault_i;
    set_a[`DEIU_BIT_LOCK] = lock_lost;
    set_b[`DEIU_BIT_SYNC] = second_chan_sync_fault_i;
    set_b[`DEIU_BIT_CRC] = second_chan_checksum_fault_i;
    set_b[`DEIU_BIT_UNC] = second_chan_header_uncorrectable_i;
    set_b[`DEIU_BIT_COR] = second_chan_header_corrected_i;
    set_b[`DEIU_BIT_LLP] = second_chan_protocol_fault_i | second_chan_lane_merge_fault_i;
    set_b[`DEIU_BIT_SOT] = second_chan_leader_fault_i;
  end
  // no soft reset input reaches the set terms above

  // ************************************************
  // register writes
  // ************************************************
  wire wr_ctrl = reg_wr_i & (reg_addr_i == `DEIU_ADDR_IRQ_CTRL);
  wire wr_en_a = reg_wr_i & (reg_addr_i == `DEIU_ADDR_EN_A);
  wire wr_en_b = reg_wr_i & (reg_addr_i == `DEIU_ADDR_EN_B);
  wire wr_st_a = reg_wr_i & (reg_addr_i == `DEIU_ADDR_STAT_A);
  wire wr_st_b = reg_wr_i & (reg_addr_i == `DEIU_ADDR_STAT_B);
  wire [7:0] clr_a = wr_st_a ? reg_wdata_i : `DEIU_RST_ZERO;
  wire [7:0] clr_b = wr_st_b ? reg_wdata_i : `DEIU_RST_ZERO;

  reg [7:0] ctrl_ff;
  reg [7:0] en_a_ff;
  reg [7:0] en_b_ff;
  // enable registers, unused bits held at zero
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      ctrl_ff <= `DEIU_RST_ZERO;
      en_a_ff <= `DEIU_RST_ZERO;
      en_b_ff <= `DEIU_RST_ZERO;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= reg_wdata_i & `DEIU_MASK_CTRL;
      if (wr_en_a)
        en_a_ff <= reg_wdata_i & `DEIU_MASK_A;
      if (wr_en_b)
        en_b_ff <= reg_wdata_i & `DEIU_MASK_B;
    end
  end

  // ************************************************
  // sticky status registers
  // ************************************************
  wire [7:0] stat_a;
  wire [7:0] stat_b;
  deiu_w1c_reg #(
    .RST_VAL(`DEIU_RST_STAT_A),
    .IMPL_MASK(`DEIU_MASK_A)
  ) u_stat_a (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .set_i(set_a),
    .clr_i(clr_a),
    .flag_o(stat_a)
  );
  deiu_w1c_reg #(
    .RST_VAL(`DEIU_RST_STAT_B),
    .IMPL_MASK(`DEIU_MASK_B)
  ) u_stat_b (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .set_i(set_b),
    .clr_i(clr_b),
    .flag_o(stat_b)
  );

  // ************************************************
  // read data register
  // ************************************************
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  // unmapped addresses read zero
  always @*
  begin
    case (reg_addr_i)
      `DEIU_ADDR_IRQ_CTRL: nxt_rdata = ctrl_ff;
      `DEIU_ADDR_EN_A: nxt_rdata = en_a_ff;
      `DEIU_ADDR_EN_B: nxt_rdata = en_b_ff;
      `DEIU_ADDR_STAT_A: nxt_rdata = stat_a;
      `DEIU_ADDR_STAT_B: nxt_rdata = stat_b;
      default: nxt_rdata = `DEIU_RST_ZERO;
    endcase
  end
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
      rdata_ff <= `DEIU_RST_ZERO;
    else if (reg_rd_i)
      rdata_ff <= nxt_rdata;
  end
  assign reg_rdata_o = rdata_ff;

  // ************************************************
  // interrupt pin
  // ************************************************
  wire any_pend = |(stat_a & en_a_ff) | |(stat_b & en_b_ff);
  reg irq_ff;
  // registered so it drops the cycle after the last clear
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
      irq_ff <= 1'b0;
    else
      irq_ff <= any_pend & ctrl_ff[`DEIU_BIT_IRQ_EN];
  end
  assign irq_o = irq_ff;
  assign irq_oe_o = ctrl_ff[`DEIU_BIT_IRQ_EN] & irq_ff;
endmodule

// ===== design/deiu_consts.vh
// constants for the dsi error interrupt unit
`ifndef DEIU_CONSTS_VH
`define DEIU_CONSTS_VH
`define DEIU_ADDR_W 8
`define DEIU_DATA_W 8
`define DEIU_ADDR_IRQ_CTRL 8'he0
`define DEIU_ADDR_EN_A 8'he1
`define DEIU_ADDR_EN_B 8'he2
`define DEIU_ADDR_STAT_A 8'he5
`define DEIU_ADDR_STAT_B 8'he6
`define DEIU_BIT_SYNC 7
`define DEIU_BIT_CRC 6
`define DEIU_BIT_UNC 5
`define DEIU_BIT_COR 4
`define DEIU_BIT_LLP 3
`define DEIU_BIT_SOT 2
`define DEIU_BIT_LOCK 0
`define DEIU_BIT_IRQ_EN 0
`define DEIU_ERR_LO 2
`define DEIU_ERR_HI 7
`define DEIU_MASK_A 8'hfd
`define DEIU_MASK_B 8'hfc
`define DEIU_MASK_CTRL 8'h01
`define DEIU_RST_STAT_A 8'h01
`define DEIU_RST_STAT_B 8'h00
`define DEIU_RST_ZERO 8'h00
`endif

// ===== design/deiu_sync2.v
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
module deiu_sync2 (
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // level in and out
  input wire d_i,
  output wire q_o
);
  reg s1_ff;
  reg s2_ff;
  // first stage read only by second stage
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
    end
  end
  assign q_o = s2_ff;
endmodule

// ===== design/deiu_w1c_reg.v
// sticky status register with write-one-to-clear bits
`timescale 1ns/10ps
`include "deiu_consts.vh"
module deiu_w1c_reg #(
  parameter [7:0] RST_VAL = 8'h00,
  parameter [7:0] IMPL_MASK = 8'hff
) (
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // event and clear strobes
  input wire [7:0] set_i,
  input wire [7:0] clr_i,
  // flags
  output wire [7:0] flag_o
);
  reg [7:0] flag_ff;
  wire [7:0] nxt_flag;
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      // set wins over clear, writes of 0 leave bit alone
      assign nxt_flag[i] = IMPL_MASK[i] & (set_i[i] | (flag_ff[i] & ~clr_i[i]));
    end
  endgenerate
  // flags keep their value until cleared
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
      flag_ff <= RST_VAL & IMPL_MASK;
    else
      flag_ff <= nxt_flag;
  end
  assign flag_o = flag_ff;
endmodule

// ===== verif/deiu_assertions.sv
// port level checks of the error interrupt unit
`timescale 1ns/10ps
module deiu_chk (
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  // strobes and pin
  input wire first_chan_sync_fault_i,
  input wire second_chan_leader_fault_i,
  input wire irq_o,
  input wire irq_oe_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_SYNC_A: assert property (first_chan_sync_fault_i ##1 (reg_rd_i && reg_addr_i == 8'he5)
    |=> reg_rdata_o[7]) else $error("sync flag missing");
  AST_LEAD_B: assert property (second_chan_leader_fault_i ##1 (reg_rd_i && reg_addr_i == 8'he6)
    |=> reg_rdata_o[2]) else $error("leader flag missing");
  AST_CLR_ONE: assert property ((reg_wr_i && reg_addr_i == 8'he5 && reg_wdata_i[7]
    && !first_chan_sync_fault_i) ##1 (reg_rd_i && reg_addr_i == 8'he5) |=> !reg_rdata_o[7])
    else $error("flag not cleared");
  AST_OE_IRQ: assert property (irq_oe_o |-> irq_o) else $error("pin driven low");
  AST_GLB_OFF: assert property ((reg_wr_i && reg_addr_i == 8'he0 && !reg_wdata_i[0])
    |-> ##2 (!irq_o && !irq_oe_o)) else $error("irq while disabled");
  AST_STB_LOW: assert property ((reg_rd_i && reg_addr_i == 8'he6)
    |=> reg_rdata_o[1:0] == 2'b00) else $error("status b low bits set");
  AST_CTL_LOW: assert property ((reg_rd_i && reg_addr_i == 8'he0)
    |=> reg_rdata_o[7:1] == 7'h00) else $error("control bits set");
  AST_ENA_LOW: assert property ((reg_rd_i && reg_addr_i == 8'he1)
    |=> !reg_rdata_o[1]) else $error("enable a bit 1 set");
  AST_ENB_LOW: assert property ((reg_rd_i && reg_addr_i == 8'he2)
    |=> reg_rdata_o[1:0] == 2'b00) else $error("enable b low bits set");
  // main scenarios reached
  cover property (irq_oe_o);
  cover property (reg_wr_i && reg_addr_i == 8'he6);
  cover property ($fell(irq_o));
endmodule

// ===== verif/deiu_host_model.sv
// host interrupt input with a pull-down on the line
`timescale 1ns/10ps
module deiu_host_model (
  // pin from the bridge
  input wire irq_o,
  input wire irq_oe_o,
  // level seen by the host
  output wire irq_seen_o
);
  // a floating pin settles at the pull-down level
  assign irq_seen_o = irq_oe_o ? irq_o : 1'b0;
endmodule

// ===== verif/deiu_top_test.sv
// self-checking bench for the error interrupt unit
`timescale 1ns/10ps
module deiu_top_test;
  logic mclk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, pll_lock_i = 1, rd_d = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, m, a;
  logic [7:1] fa = 7'h00, fb = 7'h00;
  logic [31:0] seed = 32'h49;
  logic [7:0] exp_q[$];
  wire [7:0] reg_rdata_o;
  wire irq_o, irq_oe_o, irq_seen;
  int n_fail = 0, check_count = 0, cyc = 0;
  // clock
  always #50 mclk_i = ~mclk_i;
  deiu_top dut_u (.*,
    .first_chan_sync_fault_i(fa[7]), .first_chan_checksum_fault_i(fa[6]),
    .first_chan_header_uncorrectable_i(fa[5]), .first_chan_header_corrected_i(fa[4]),
    .first_chan_protocol_fault_i(fa[3]), .first_chan_leader_fault_i(fa[2]),
    .first_chan_lane_merge_fault_i(fa[1]), .second_chan_sync_fault_i(fb[7]),
    .second_chan_checksum_fault_i(fb[6]), .second_chan_header_uncorrectable_i(fb[5]),
    .second_chan_header_corrected_i(fb[4]), .second_chan_protocol_fault_i(fb[3]),
    .second_chan_leader_fault_i(fb[2]), .second_chan_lane_merge_fault_i(fb[1]));
  deiu_host_model host_u (.irq_o(irq_o), .irq_oe_o(irq_oe_o), .irq_seen_o(irq_seen));
  function automatic logic [31:0] nx(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task conclude;
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_i = ad;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(negedge mclk_i);
    exp_q.push_back(e);
    reg_addr_i = ad;
    reg_rd_i = 1'b1;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
  endtask
  task automatic hit(input int ch, input int k);
    @(negedge mclk_i);
    if (ch == 1)
      fb[k] = 1'b1;
    else
      fa[k] = 1'b1;
    @(negedge mclk_i);
    fa = 7'h00;
    fb = 7'h00;
  endtask
  // read data watcher and hang limit
  always @(posedge mclk_i)
  begin
    if (rd_d)
      cmp(reg_rdata_o, exp_q.pop_front());
    rd_d <= reg_rd_i;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      conclude;
    end
  end
  // main sequence
  initial
  begin
    repeat (2) @(negedge mclk_i);
    rstn_i = 1'b1;
    rd(8'he5, 8'h01);
    rd(8'he6, 8'h00);
    for (int i = 0; i < 4; i++)
      rd(i == 3 ? 8'h10 : 8'he0 + i[7:0], 8'h00);
    wr(8'he0, 8'hff);
    wr(8'he1, 8'hff);
    wr(8'he2, 8'hff);
    rd(8'he0, 8'h01);
    rd(8'he1, 8'hfd);
    rd(8'he2, 8'hfc);
    cmp({7'h00, irq_seen}, 8'h01);
    wr(8'he5, 8'h01);
    for (int ch = 0; ch < 2; ch++)
      for (int k = 1; k < 8; k++)
      begin
        a = ch ? 8'he6 : 8'he5;
        m = k == 1 ? 8'h08 : 8'h01 << k;
        hit(ch, k);
        rd(a, m);
        cmp({7'h00, irq_seen}, 8'h01);
        wr(a, 8'h00);
        rd(a, m);
        seed = nx(seed);
        wr(a, seed[7:0] | m);
        rd(a, 8'h00);
        cmp({7'h00, irq_seen}, 8'h00);
      end
    wr(8'he1, 8'h00);
    hit(0, 7);
    rd(8'he5, 8'h80);
    cmp({7'h00, irq_seen}, 8'h00);
    wr(8'he0, 8'h00);
    wr(8'he1, 8'hfc);
    rd(8'he5, 8'h80);
    cmp({7'h00, irq_oe_o}, 8'h00);
    wr(8'he5, 8'h80);
    wr(8'he1, 8'h01);
    wr(8'he0, 8'h01);
    pll_lock_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    rd(8'he5, 8'h01);
    cmp({7'h00, irq_seen}, 8'h01);
    @(negedge mclk_i);
    conclude;
  end
endmodule
bind deiu_top deiu_chk chk_u (.*);
